// [pkg/tx_dl_pkg.sv]
// Package for the transmit data-link message controller: register map, fields, reset values, types.
// Assumes a byte-wide register port and a 40 MHz framer clock.
package tx_dl_pkg;
   localparam logic [11:0] ADDR_CONTROL    = 12'h113;
   localparam logic [11:0] ADDR_COUNT      = 12'h114;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h118;
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'h119;
   localparam logic [11:0] BUF0_BASE       = 12'h600;
   localparam logic [11:0] BUF1_BASE       = 12'h700;
   localparam int          BUF_SEL_BIT     = 7;
   localparam int          FCS_EN_BIT      = 1;
   localparam int          TYPE_SEL_BIT    = 0;
   localparam logic [7:0]  CONTROL_RESET   = 8'h00;
   localparam logic [7:0]  COUNT_RESET     = 8'h00;
   localparam logic [7:0]  FLAG_OCTET      = 8'h7E;
   localparam logic [15:0] CRC_INIT        = 16'hFFFF;
   localparam logic [15:0] CRC_POLY_REFL   = 16'h8408;
   localparam int          IRQ_EOT_BIT     = 0;
   localparam int          IRQ_MSG_DONE_BIT = 1;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] octet;
   } octet_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_FETCH  = 3'b001,
      ST_SEND   = 3'b011,
      ST_CHECK0 = 3'b010,
      ST_CHECK1 = 3'b110,
      ST_CLOSE  = 3'b111
   } tx_state_t;
endpackage

// [verilog/tx_msg_buffer.sv]
// Two ping-pong transmit message buffers, written by the host and read by the controller.
// Assumes one clock; read data appear one cycle after the read address.
`timescale 1ns/1ps
`default_nettype none
module tx_msg_buffer #(
   parameter int DEPTH = 128
) (
   // Clock
   input  wire logic                     clk,
   // Host write side
   input  wire logic                     writeEnable,
   input  wire logic                     writeBank,
   input  wire logic [$clog2(DEPTH)-1:0] writeAddr,
   input  wire logic [7:0]               writeData,
   // Controller read side
   input  wire logic                     readBank,
   input  wire logic [$clog2(DEPTH)-1:0] readAddr,
   output logic      [7:0]               readData
);
   logic [7:0] store [0:2*DEPTH-1];

   always_ff @(posedge clk) begin
      if (writeEnable) begin
         store[{writeBank, writeAddr}] <= writeData;
      end
   end

   always_ff @(posedge clk) begin
      readData <= store[{readBank, readAddr}];
   end
endmodule
`default_nettype wire

// [verilog/tx_datalink_msg_control.sv]
// Transmit data-link message controller: control registers, ping-pong buffers, octet stream out.
// Assumes a host register port on the framer clock and a framer that pulls one octet per octetReady.
// Behaviour
// - Message mode with check enable appends check octets
// - Bit mode ignores the check enable setting
// - Type select: zero bit-oriented, one message
// - Buffer select write starts sending that buffer, except in message mode with count zero
// - Buffer bit read returns next free buffer
// - Busy buffer makes read show the other
// - Bit mode: count repetitions then interrupt, stop
// - Bit mode count zero repeats forever
// - Message mode count is length without check
// - Idle message channel sends flag octets
`timescale 1ns/1ps
`default_nettype none
module tx_datalink_msg_control #(
   parameter int DEPTH = 128
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                reset_n,
   // Register port
   input  wire logic [11:0]         regAddr,
   input  wire logic [7:0]          regWriteData,
   input  wire logic                regWrite,
   input  wire logic                regRead,
   output logic      [7:0]          regReadData,
   // Octet stream toward the data-link channel
   input  wire logic                octetReady,
   output tx_dl_pkg::octet_t        txOctet,
   output logic                     txMessageOriented,
   // Interrupt
   output logic                     irq
);
   localparam int AW = $clog2(DEPTH);

   logic [7:0]            control;
   logic [7:0]            countField;
   logic [1:0]            irqStatus;
   logic [1:0]            irqMask;
   logic                  activeBank;
   logic [1:0]            pending;
   tx_dl_pkg::tx_state_t  state;
   logic [6:0]            octetIndex;
   logic [6:0]            repsDone;
   logic [15:0]           crc;
   logic [7:0]            bufData;
   logic                  bufWrite;
   logic                  bufWriteBank;
   logic [AW-1:0]         bufReadAddr;
   logic                  messageMode;
   logic                  checkEnable;
   logic                  eotEvent;
   logic                  msgDoneEvent;
   logic                  nextFree;
   logic                  lastOctet;
   logic [15:0]           next_crc;
   logic                  shown;
   logic                  accept;

   assign messageMode = control[tx_dl_pkg::TYPE_SEL_BIT];
   assign checkEnable = messageMode & control[tx_dl_pkg::FCS_EN_BIT];
   assign lastOctet   = (octetIndex == countField[6:0] - 7'd1);
   assign accept      = shown && octetReady;

   // Host buffer writes land in the bank chosen by the top address bits.
   assign bufWrite     = regWrite && (regAddr[11:8] == tx_dl_pkg::BUF0_BASE[11:8]
                                    || regAddr[11:8] == tx_dl_pkg::BUF1_BASE[11:8]);
   assign bufWriteBank = (regAddr[11:8] == tx_dl_pkg::BUF1_BASE[11:8]);

   tx_msg_buffer #(
      .DEPTH       (DEPTH)
   ) u_buffer (
      .clk         (clk),
      .writeEnable (bufWrite),
      .writeBank   (bufWriteBank),
      .writeAddr   (regAddr[AW-1:0]),
      .writeData   (regWriteData),
      .readBank    (activeBank),
      .readAddr    (bufReadAddr),
      .readData    (bufData)
   );

   // Control register.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         control <= tx_dl_pkg::CONTROL_RESET;
      end else if (regWrite && regAddr == tx_dl_pkg::ADDR_CONTROL) begin
         control <= regWriteData;
      end
   end

   // Count field; the buffer bit itself is not stored, it is a command on write.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         countField <= tx_dl_pkg::COUNT_RESET;
      end else if (regWrite && regAddr == tx_dl_pkg::ADDR_COUNT) begin
         countField <= {1'b0, regWriteData[6:0]};
      end
   end

   // Pending flags per buffer: set by a select write, cleared only when the transfer closes.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pending <= 2'b00;
      end else begin
         if (state == tx_dl_pkg::ST_CLOSE) begin
            pending[activeBank] <= 1'b0;
         end
         if (regWrite && regAddr == tx_dl_pkg::ADDR_COUNT) begin
            pending[regWriteData[tx_dl_pkg::BUF_SEL_BIT]] <= 1'b1;
         end
      end
   end

   // Next free buffer: the other one while a buffer is still owned by the controller.
   always_comb begin
      if (pending[0] && !pending[1]) begin
         nextFree = 1'b1;
      end else if (pending[1] && !pending[0]) begin
         nextFree = 1'b0;
      end else begin
         nextFree = ~activeBank;
      end
   end

   // LAPD CRC over one octet, least significant bit first.
   always_comb begin
      next_crc = crc;
      for (int i = 0; i < 8; i++) begin
         if (next_crc[0] ^ bufData[i]) begin
            next_crc = (next_crc >> 1) ^ tx_dl_pkg::CRC_POLY_REFL;
         end else begin
            next_crc = next_crc >> 1;
         end
      end
   end

   // Transmit sequencer.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state       <= tx_dl_pkg::ST_IDLE;
         activeBank  <= 1'b0;
         octetIndex  <= 7'd0;
         repsDone    <= 7'd0;
         crc         <= tx_dl_pkg::CRC_INIT;
         bufReadAddr <= '0;
      end else begin
         case (state)
            tx_dl_pkg::ST_IDLE: begin
               if (pending != 2'b00 && countField[6:0] != 7'd0 || pending != 2'b00 && !messageMode) begin
                  activeBank  <= pending[0] ? 1'b0 : 1'b1;
                  octetIndex  <= 7'd0;
                  repsDone    <= 7'd0;
                  crc         <= tx_dl_pkg::CRC_INIT;
                  bufReadAddr <= '0;
                  state       <= tx_dl_pkg::ST_FETCH;
               end
            end
            tx_dl_pkg::ST_FETCH: begin
               state <= tx_dl_pkg::ST_SEND;
            end
            tx_dl_pkg::ST_SEND: begin
               if (accept) begin
                  if (messageMode) begin
                     crc <= next_crc;
                     if (lastOctet || countField[6:0] == 7'd0) begin
                        state <= checkEnable ? tx_dl_pkg::ST_CHECK0 : tx_dl_pkg::ST_CLOSE;
                     end else begin
                        octetIndex  <= octetIndex + 7'd1;
                        bufReadAddr <= AW'(octetIndex + 7'd1);
                        state       <= tx_dl_pkg::ST_FETCH;
                     end
                  end else begin
                     // Bit-oriented messages are two octets repeated.
                     if (octetIndex == 7'd1) begin
                        octetIndex  <= 7'd0;
                        bufReadAddr <= '0;
                        if (countField[6:0] != 7'd0 && repsDone + 7'd1 == countField[6:0]) begin
                           state <= tx_dl_pkg::ST_CLOSE;
                        end else begin
                           repsDone <= (countField[6:0] == 7'd0) ? 7'd0 : repsDone + 7'd1;
                           state    <= tx_dl_pkg::ST_FETCH;
                        end
                     end else begin
                        octetIndex  <= 7'd1;
                        bufReadAddr <= AW'(1);
                        state       <= tx_dl_pkg::ST_FETCH;
                     end
                  end
               end
            end
            tx_dl_pkg::ST_CHECK0: begin
               if (accept) begin
                  state <= tx_dl_pkg::ST_CHECK1;
               end
            end
            tx_dl_pkg::ST_CHECK1: begin
               if (accept) begin
                  state <= tx_dl_pkg::ST_CLOSE;
               end
            end
            tx_dl_pkg::ST_CLOSE: begin
               state <= tx_dl_pkg::ST_IDLE;
            end
            default: begin
               state <= tx_dl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign eotEvent     = (state == tx_dl_pkg::ST_CLOSE) && !messageMode;
   assign msgDoneEvent = (state == tx_dl_pkg::ST_CLOSE) && messageMode;

   // Each octet is shown before it can be taken; gaps inside a frame are not valid, so no stray flag.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txOctet <= '{valid: 1'b0, octet: 8'h00};
         shown   <= 1'b0;
      end else begin
         case (state)
            tx_dl_pkg::ST_SEND, tx_dl_pkg::ST_CHECK0, tx_dl_pkg::ST_CHECK1: begin
               if (!shown) begin
                  shown         <= 1'b1;
                  txOctet.valid <= 1'b1;
                  txOctet.octet <= (state == tx_dl_pkg::ST_SEND)   ? bufData
                                 : (state == tx_dl_pkg::ST_CHECK0) ? ~crc[7:0] : ~crc[15:8];
               end else if (accept) begin
                  shown         <= 1'b0;
                  txOctet.valid <= 1'b0;
               end
            end
            tx_dl_pkg::ST_FETCH: shown <= 1'b0;
            default: txOctet <= '{valid: 1'b1, octet: tx_dl_pkg::FLAG_OCTET};
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txMessageOriented <= 1'b0;
      end else begin
         txMessageOriented <= messageMode;
      end
   end

   // Sticky interrupt status, write one to clear; a new event wins over the clear.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqStatus <= 2'b00;
      end else begin
         if (regWrite && regAddr == tx_dl_pkg::ADDR_IRQ_STATUS) begin
            irqStatus <= irqStatus & ~regWriteData[1:0];
         end
         if (eotEvent) begin
            irqStatus[tx_dl_pkg::IRQ_EOT_BIT] <= 1'b1;
         end
         if (msgDoneEvent) begin
            irqStatus[tx_dl_pkg::IRQ_MSG_DONE_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqMask <= 2'b00;
      end else if (regWrite && regAddr == tx_dl_pkg::ADDR_IRQ_MASK) begin
         irqMask <= regWriteData[1:0];
      end
   end

   assign irq = |(irqStatus & irqMask);

   // Read data, valid in the cycle after the read strobe; unmapped addresses read zero.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regReadData <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            tx_dl_pkg::ADDR_CONTROL:    regReadData <= control;
            tx_dl_pkg::ADDR_COUNT:      regReadData <= {nextFree, countField[6:0]};
            tx_dl_pkg::ADDR_IRQ_STATUS: regReadData <= {6'h00, irqStatus};
            tx_dl_pkg::ADDR_IRQ_MASK:   regReadData <= {6'h00, irqMask};
            default:                    regReadData <= 8'h00;
         endcase
      end else begin
         regReadData <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// [verification/tx_datalink_msg_control_chk.sv]
// Checker for the transmit data-link message controller, watching only its top-level ports.
// Assumes one clock domain and the register map of tx_dl_pkg.
`timescale 1ns/1ps
`default_nettype none
module tx_datalink_msg_control_chk #(
   parameter int DEPTH = 128
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Register port
   input  wire logic [11:0]       regAddr,
   input  wire logic [7:0]        regWriteData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   input  wire logic [7:0]        regReadData,
   // Octet stream and interrupt
   input  wire logic              octetReady,
   input  wire tx_dl_pkg::octet_t txOctet,
   input  wire logic              txMessageOriented,
   input  wire logic              irq
);
   logic       started;
   logic [1:0] maskShadow;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         started    <= 1'b0;
         maskShadow <= 2'h0;
      end else begin
         if (regWrite && regAddr == tx_dl_pkg::ADDR_COUNT) begin
            started <= 1'b1;
         end
         if (regWrite && regAddr == tx_dl_pkg::ADDR_IRQ_MASK) begin
            maskShadow <= regWriteData[1:0];
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   read_slot_a: assert property (!$past(regRead) |-> regReadData == 8'h00)
      else $error("Read data outside its slot");
   unmapped_read_a: assert property (regRead && regAddr[11:8] == 4'h2 |=> regReadData == 8'h00)
      else $error("Unmapped read not zero");
   mask_read_a: assert property (regRead && regAddr == tx_dl_pkg::ADDR_IRQ_MASK |=> regReadData[1:0] == maskShadow)
      else $error("Mask readback wrong");
   mask_off_a: assert property (regWrite && regAddr == tx_dl_pkg::ADDR_IRQ_MASK && regWriteData[1:0] == 2'h0 |=> !irq)
      else $error("Interrupt with mask cleared");
   irq_hold_a: assert property (irq && !regWrite |=> irq)
      else $error("Interrupt dropped without a write");
   type_copy_a: assert property (regWrite && regAddr == tx_dl_pkg::ADDR_CONTROL |-> ##2
      txMessageOriented == $past(regWriteData[tx_dl_pkg::TYPE_SEL_BIT], 2)) else $error("Type output wrong");
   stream_gap_a: assert property (!txOctet.valid |-> ##[1:2] txOctet.valid)
      else $error("Octet stream gap too long");
   idle_flag_a: assert property (!started && $past(reset_n) |-> txOctet.octet == tx_dl_pkg::FLAG_OCTET)
      else $error("Idle channel not sending flags");
   cover property (irq);
   cover property (regRead && regAddr == tx_dl_pkg::ADDR_COUNT);
   cover property ($rose(txMessageOriented));
endmodule
bind tx_datalink_msg_control tx_datalink_msg_control_chk #(.DEPTH(DEPTH)) chk (.clk(clk), .reset_n(reset_n),
   .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .octetReady(octetReady), .txOctet(txOctet),
   .txMessageOriented(txMessageOriented), .irq(irq));
`default_nettype wire

// [verification/framer_pull_model.sv]
// Framer model: pulls octets from the controller and logs each octet taken.
// Assumes the octet stream protocol of tx_datalink_msg_control.
`timescale 1ns/1ps
`default_nettype none
module framer_pull_model (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Octet stream
   input  wire tx_dl_pkg::octet_t txOctet,
   input  wire logic              slow,
   output logic                   octetReady
);
   logic [1:0] gap;
   logic [7:0] got[$];
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap <= 2'h0;
      end else begin
         gap <= gap + 2'h1;
         if (octetReady && txOctet.valid) begin
            got.push_back(txOctet.octet);
         end
      end
   end
   // A slow framer takes one octet in four cycles.
   assign octetReady = reset_n && (!slow || gap == 2'h3);
endmodule
`default_nettype wire

// [verification/tx_datalink_msg_control_tb.sv]
// Testbench for the transmit data-link message controller.
// Assumes the checker is bound and the framer model pulls the octet stream.
`timescale 1ns/1ps
`default_nettype none
module tx_datalink_msg_control_tb;
   typedef struct {logic wr; logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic              clk, reset_n, regWrite, regRead, octetReady, txMessageOriented, irq, slow;
   logic [11:0]       regAddr;
   logic [7:0]        regWriteData, regReadData, v;
   tx_dl_pkg::octet_t txOctet;
   logic [7:0]        msg[$];
   logic [15:0]       c;
   int                mismatches, checks;
   row_t rows[6] = '{'{0, 12'h113, 8'h00, 8'h00}, '{0, 12'h118, 8'h00, 8'h00}, '{0, 12'h119, 8'h00, 8'h00},
                     '{1, 12'h119, 8'h03, 8'h03}, '{1, 12'h200, 8'h5A, 8'h00}, '{1, 12'h119, 8'h00, 8'h00}};
   tx_datalink_msg_control #(.DEPTH(128)) DUT (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
      .octetReady(octetReady), .txOctet(txOctet), .txMessageOriented(txMessageOriented), .irq(irq));
   framer_pull_model M (.clk(clk), .reset_n(reset_n), .txOctet(txOctet), .slow(slow), .octetReady(octetReady));
   task automatic end_sim;
      if (mismatches == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regReadData;
   endtask
   function automatic logic [15:0] fcs(input logic [7:0] q[$]);
      logic [15:0] r;
      r = tx_dl_pkg::CRC_INIT;
      foreach (q[i]) begin
         r = r ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) r = r[0] ? (r >> 1) ^ tx_dl_pkg::CRC_POLY_REFL : r >> 1;
      end
      return ~r;
   endfunction
   // Loads msg into the bank that cnt selects, starts it and, when st is nonzero, waits for irq and checks the status bits against st.
   task automatic send(input logic [7:0] ctl, input logic [7:0] cnt, input logic [7:0] st);
      for (int i = 0; i < msg.size(); i++) wr((cnt[7] ? tx_dl_pkg::BUF1_BASE : tx_dl_pkg::BUF0_BASE) + 12'(i), msg[i]);
      wr(tx_dl_pkg::ADDR_CONTROL, ctl);
      M.got.delete();
      wr(tx_dl_pkg::ADDR_COUNT, cnt);
      rd(tx_dl_pkg::ADDR_COUNT, v);
      check(v[7], !cnt[7]);
      for (int i = 0; i < 3000 && irq !== 1'b1 && st != 8'h00; i++) @(posedge clk);
      if (st != 8'h00) begin
         rd(tx_dl_pkg::ADDR_IRQ_STATUS, v);
         check(v, st);
         wr(tx_dl_pkg::ADDR_IRQ_STATUS, st);
         rd(tx_dl_pkg::ADDR_COUNT, v);
         check(irq, 1'b0);
         check(v[7], !cnt[7]);
      end
   endtask
   // Compares the logged octets, after leading flags, with exp.
   task automatic compareLog(input logic [7:0] exp[$]);
      logic [7:0] g[$];
      g = M.got;
      while (g.size() > 0 && g[0] == tx_dl_pkg::FLAG_OCTET) void'(g.pop_front());
      foreach (exp[i]) check(i < g.size() ? g[i] : 8'hXX, exp[i]);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #(25ns * 40000);
      mismatches++;
      end_sim();
   end
   initial begin
      reset_n = 1'b0;
      {regWrite, regRead, slow, regAddr, regWriteData} = '0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         check(v, rows[i].e);
      end
      check(txOctet, 16'h017E);
      wr(tx_dl_pkg::ADDR_IRQ_MASK, 8'h03);
      slow <= 1'b1;
      msg = '{8'h01, 8'h02, 8'h03, 8'h04};
      c = fcs(msg);
      send(8'h03, 8'h04, 8'h02);
      compareLog('{8'h01, 8'h02, 8'h03, 8'h04, c[7:0], c[15:8], 8'h7E});
      slow <= 1'b0;
      msg = '{8'h11, 8'h22, 8'h33};
      send(8'h01, 8'h83, 8'h02);
      compareLog('{8'h11, 8'h22, 8'h33, 8'h7E});
      msg = '{8'hA5, 8'h3C};
      send(8'h02, 8'h02, 8'h01);
      compareLog('{8'hA5, 8'h3C, 8'hA5, 8'h3C, 8'h7E});
      msg = '{8'hB1, 8'hB2};
      send(8'h00, 8'h80, 8'h00);
      repeat (60) @(posedge clk);
      check(irq, 1'b0);
      compareLog('{8'hB1, 8'hB2, 8'hB1, 8'hB2, 8'hB1, 8'hB2});
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check(txOctet, 16'h017E);
      end_sim();
   end
endmodule
`default_nettype wire
